// file: rtl/psm_defs.svh
// register map, field positions, reset values and timing counts of the power-state block
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH
`define PSM_AW 8
`define PSM_DW 32
`define PSM_OFS_CORE_PWR 8'h00
`define PSM_OFS_CFG 8'h04
`define PSM_OFS_SCAN_IN_PULL 8'h08
`define PSM_OFS_SCAN_OUT_PULL 8'h0C
`define PSM_OFS_GPIO7_PULL 8'h10
`define PSM_OFS_STATUS 8'h14
`define PSM_BIT_IDLE 0
`define PSM_BIT_PWR_DOWN 1
`define PSM_BIT_PLL_SLEEP 0
`define PSM_ST_MODE_LO 0
`define PSM_ST_MODE_HI 1
`define PSM_ST_HOST_ON 2
`define PSM_ST_STRAP_DONE 3
`define PSM_ST_STRAP_LO 4
`define PSM_ST_STRAP_HI 7
`define PSM_CODE_NORMAL 2'h0
`define PSM_CODE_IDLE 2'h1
`define PSM_CODE_DOZE 2'h2
`define PSM_CODE_SLEEP 2'h3
`define PSM_SCAN_IN_RST 8'h00
`define PSM_SCAN_OUT_RST 16'h0000
`define PSM_GPIO7_RST 8'h00
`define PSM_FLASH_ADDR_RST 22'h00003C
`define PSM_STRAP_PIN_LO 2
`define PSM_STRAP_PIN_HI 5
`define PSM_STRAP_NS 160
`define PSM_CLK_NS 10
`define PSM_STRAP_CYC ((`PSM_STRAP_NS + `PSM_CLK_NS - 1) / `PSM_CLK_NS)
`endif

// file: rtl/psm_pkg.sv
// types shared by the power-state block
package psm_pkg;
  typedef enum logic [1:0] {PSM_NORMAL, PSM_IDLE, PSM_DOZE, PSM_SLEEP} psm_mode_t;
endpackage

// file: rtl/psm_flash_pull.sv
// flash pin pull-down control and strap sampling
`timescale 1ns/1ps
`default_nettype none
`include "psm_defs.svh"
module psm_flash_pull
  import psm_pkg::*;
#(
  parameter int STRAP_CYC = `PSM_STRAP_CYC
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic clk_en, // freezes state while low
  input wire logic power_saving, // chip is in a saving mode
  input wire logic [3:0] strap_pins, // flash_address_pins[5:2] level
  output logic [21:0] flash_addr_pull, // address pin pull-downs
  output logic [7:0] flash_data_pull, // data pin pull-downs
  output logic [2:0] flash_ctl_pull, // chip-select, read, write pull-downs
  output logic strap_done, // strap level captured
  output logic [3:0] strap_value // captured strap level
);
  logic [7:0] strap_cnt;
  logic next_done;

  assign next_done = (strap_cnt == 8'(STRAP_CYC));

  // =====================================================
  // strap sampling
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      strap_cnt <= 8'h00;
      strap_done <= 1'b0;
      strap_value <= 4'h0;
    end else if (clk_en && !strap_done) begin
      if (next_done) begin
        strap_done <= 1'b1;
        strap_value <= strap_pins;
      end else begin
        strap_cnt <= strap_cnt + 8'h01;
      end
    end
  end

  // =====================================================
  // pull-downs
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      flash_addr_pull <= `PSM_FLASH_ADDR_RST; // strap pins pulled from power-on
      flash_data_pull <= 8'h00;
      flash_ctl_pull <= 3'h0;
    end else if (clk_en) begin
      flash_addr_pull <= {22{power_saving}};
      flash_addr_pull[`PSM_STRAP_PIN_HI:`PSM_STRAP_PIN_LO] <= {4{power_saving || !(strap_done || next_done)}};
      flash_data_pull <= {8{power_saving}};
      flash_ctl_pull <= {3{power_saving}};
    end
  end

  a_strap_pull: assert property (@(posedge mclk) disable iff (sys_rst)
    !strap_done |-> flash_addr_pull[`PSM_STRAP_PIN_HI:`PSM_STRAP_PIN_LO] == 4'hF)
    else $error("strap pins not pulled before sampling");
endmodule
`default_nettype wire

// file: rtl/psm_top.sv
// power-state module gating: mode control, clock enables, host power and pin pulls
`timescale 1ns/1ps
`default_nettype none
`include "psm_defs.svh"
module psm_top
  import psm_pkg::*;
#(
  parameter logic [7:0] GPIO7_PULL_RST = `PSM_GPIO7_RST,
  parameter int STRAP_CYC = `PSM_STRAP_CYC
) (
  input wire logic mclk, // system clock
  input wire logic sys_rst, // synchronous reset, high
  input wire logic clk_en, // freezes all state while low
  input wire logic [`PSM_AW-1:0] reg_addr, // register byte address
  input wire logic [`PSM_DW-1:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [`PSM_DW-1:0] reg_rdata, // read data, cycle after strobe
  input wire logic interrupt_controller_unit_irq, // interrupt from the interrupt controller
  input wire logic core_timer_irq, // core internal timer interrupt
  input wire logic host_standby, // host side in Standby
  input wire logic [3:0] strap_pins, // strap level on address pins 5:2
  output logic core_fetch_en, // core instruction fetch
  output logic core_clk_en, // core timers and watchdog clock
  output logic ec_clk_en, // other EC modules clock
  output logic wake_set_clk_en, // gpio, wake, interrupt_controller_unit, pwm, scan, timer, rtc
  output logic pll_off, // pll powered down
  output logic host_unit_en, // host-facing units powered
  output logic [1:0] mode_code, // present mode
  output logic [7:0] scan_in_pull, // scan_input_pins pull-ups
  output logic [15:0] scan_out_pull, // scan_output_pins pull-ups
  output logic [7:0] gpio7_pull, // gpio_group_seven pull-downs
  output logic [21:0] flash_addr_pull, // flash address pull-downs
  output logic [7:0] flash_data_pull, // flash data pull-downs
  output logic [2:0] flash_ctl_pull // chip-select, read, write pull-downs
);
  psm_mode_t mode;
  psm_mode_t next_mode;
  logic pll_sleep_sel;
  logic strap_done;
  logic [3:0] strap_value;
  logic wr_core;
  logic next_saving;
  logic [1:0] next_code;
  logic [`PSM_DW-1:0] next_rdata;

  assign wr_core = reg_wr && (reg_addr == `PSM_OFS_CORE_PWR);

  // =====================================================
  // mode control
  always_comb begin
    next_mode = mode;
    case (mode)
      PSM_NORMAL: begin
        if (wr_core && reg_wdata[`PSM_BIT_PWR_DOWN]) begin
          next_mode = pll_sleep_sel ? PSM_SLEEP : PSM_DOZE;
        end else if (wr_core && reg_wdata[`PSM_BIT_IDLE]) begin
          next_mode = PSM_IDLE;
        end
      end
      PSM_IDLE: begin
        if (interrupt_controller_unit_irq || core_timer_irq) begin
          next_mode = PSM_NORMAL;
        end
      end
      PSM_DOZE, PSM_SLEEP: begin
        if (interrupt_controller_unit_irq) begin
          next_mode = PSM_NORMAL;
        end
      end
      default: begin
        next_mode = PSM_NORMAL;
      end
    endcase
  end

  always_comb begin
    case (next_mode)
      PSM_IDLE: next_code = `PSM_CODE_IDLE;
      PSM_DOZE: next_code = `PSM_CODE_DOZE;
      PSM_SLEEP: next_code = `PSM_CODE_SLEEP;
      default: next_code = `PSM_CODE_NORMAL;
    endcase
  end

  assign next_saving = (next_mode != PSM_NORMAL);

  // state holds unless a wake or entry event arrives
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode <= PSM_NORMAL;
      mode_code <= `PSM_CODE_NORMAL;
    end else if (clk_en) begin
      mode <= next_mode;
      mode_code <= next_code;
    end
  end

  // =====================================================
  // clock enables, all switched on one edge
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      core_fetch_en <= 1'b1;
      core_clk_en <= 1'b1;
      ec_clk_en <= 1'b1;
      wake_set_clk_en <= 1'b1;
      pll_off <= 1'b0;
    end else if (clk_en) begin
      core_fetch_en <= (next_mode == PSM_NORMAL);
      core_clk_en <= (next_mode == PSM_NORMAL) || (next_mode == PSM_IDLE);
      ec_clk_en <= (next_mode != PSM_SLEEP);
      wake_set_clk_en <= 1'b1;
      pll_off <= (next_mode == PSM_SLEEP);
    end
  end

  // =====================================================
  // host-facing power
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      host_unit_en <= 1'b0;
    end else if (clk_en) begin
      host_unit_en <= !host_standby;
    end
  end

  // =====================================================
  // configuration and pull registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pll_sleep_sel <= 1'b0;
    end else if (clk_en && reg_wr && reg_addr == `PSM_OFS_CFG) begin
      pll_sleep_sel <= reg_wdata[`PSM_BIT_PLL_SLEEP];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      scan_in_pull <= `PSM_SCAN_IN_RST;
      scan_out_pull <= `PSM_SCAN_OUT_RST;
    end else if (clk_en && reg_wr) begin
      if (reg_addr == `PSM_OFS_SCAN_IN_PULL) begin
        scan_in_pull <= reg_wdata[7:0];
      end
      if (reg_addr == `PSM_OFS_SCAN_OUT_PULL) begin
        scan_out_pull <= reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gpio7_pull <= GPIO7_PULL_RST;
    end else if (clk_en && reg_wr && reg_addr == `PSM_OFS_GPIO7_PULL) begin
      gpio7_pull <= reg_wdata[7:0];
    end
  end

  // =====================================================
  // read path
  always_comb begin
    next_rdata = '0;
    case (reg_addr)
      `PSM_OFS_CORE_PWR: next_rdata = '0;
      `PSM_OFS_CFG: next_rdata[`PSM_BIT_PLL_SLEEP] = pll_sleep_sel;
      `PSM_OFS_SCAN_IN_PULL: next_rdata[7:0] = scan_in_pull;
      `PSM_OFS_SCAN_OUT_PULL: next_rdata[15:0] = scan_out_pull;
      `PSM_OFS_GPIO7_PULL: next_rdata[7:0] = gpio7_pull;
      `PSM_OFS_STATUS: begin
        next_rdata[`PSM_ST_MODE_HI:`PSM_ST_MODE_LO] = mode_code;
        next_rdata[`PSM_ST_HOST_ON] = host_unit_en;
        next_rdata[`PSM_ST_STRAP_DONE] = strap_done;
        next_rdata[`PSM_ST_STRAP_HI:`PSM_ST_STRAP_LO] = strap_value;
      end
      default: next_rdata = '0;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      reg_rdata <= reg_rd ? next_rdata : '0;
    end
  end

  // =====================================================
  // flash pulls and strap
  psm_flash_pull #(
    .STRAP_CYC(STRAP_CYC)
  ) u_flash_pull (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .power_saving(next_saving),
    .strap_pins(strap_pins),
    .flash_addr_pull(flash_addr_pull),
    .flash_data_pull(flash_data_pull),
    .flash_ctl_pull(flash_ctl_pull),
    .strap_done(strap_done),
    .strap_value(strap_value)
  );

  // =====================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  sequence s_pdn_write;
    clk_en && mode == PSM_NORMAL && wr_core && reg_wdata[`PSM_BIT_PWR_DOWN];
  endsequence

  sequence s_wake;
    clk_en && mode != PSM_NORMAL && interrupt_controller_unit_irq;
  endsequence

  a_pdn_mode_sel: assert property (s_pdn_write |=>
    (mode == (($past(pll_sleep_sel)) ? PSM_SLEEP : PSM_DOZE)))
    else $error("power-down chose wrong mode");

  a_idle_clocks: assert property (mode == PSM_IDLE |->
    !core_fetch_en && core_clk_en && ec_clk_en)
    else $error("idle clock enables wrong");

  a_doze_clocks: assert property (mode == PSM_DOZE |->
    !core_clk_en && !core_fetch_en && ec_clk_en && !pll_off)
    else $error("doze clock enables wrong");

  a_sleep_running: assert property (mode == PSM_SLEEP |-> wake_set_clk_en)
    else $error("sleep set clock stopped");

  a_sleep_stopped: assert property (mode == PSM_SLEEP |->
    !ec_clk_en && !core_clk_en && pll_off)
    else $error("sleep left a clock running");

  a_host_power: assert property (clk_en && !sys_rst ##1 1'b1 |->
    host_unit_en == !$past(host_standby))
    else $error("host power does not follow host state");

  a_mode_hold: assert property ((!clk_en || (mode != PSM_NORMAL && !interrupt_controller_unit_irq && !core_timer_irq))
    |=> $stable(mode))
    else $error("mode moved without cause");

  a_saving_pull: assert property (clk_en ##1 (mode != PSM_NORMAL) |->
    flash_data_pull == 8'hFF && flash_ctl_pull == 3'h7 && flash_addr_pull == 22'h3FFFFF)
    else $error("flash pull-downs off in saving mode");

  a_normal_pull: assert property (mode == PSM_NORMAL && strap_done |->
    flash_data_pull == 8'h00 && flash_addr_pull == 22'h000000)
    else $error("flash pull-downs on in normal mode");

  a_scan_write: assert property (clk_en && reg_wr && reg_addr == `PSM_OFS_SCAN_IN_PULL |=>
    scan_in_pull == $past(reg_wdata[7:0]))
    else $error("scan input pull write lost");

  a_gpio7_write: assert property (clk_en && reg_wr && reg_addr == `PSM_OFS_GPIO7_PULL |=>
    gpio7_pull == $past(reg_wdata[7:0]))
    else $error("gpio group seven pull write lost");

  a_wake_together: assert property (s_wake |=>
    mode == PSM_NORMAL && core_fetch_en && core_clk_en && ec_clk_en && !pll_off)
    else $error("clocks not restored together on wake");

  // wake, refusal, freeze and read-back checks
  sequence s_idle_write;
    clk_en && mode == PSM_NORMAL && wr_core && !reg_wdata[`PSM_BIT_PWR_DOWN] && reg_wdata[`PSM_BIT_IDLE];
  endsequence

  sequence s_timer_wake;
    clk_en && mode == PSM_IDLE && core_timer_irq;
  endsequence

  sequence s_doze_no_irq;
    clk_en && mode == PSM_DOZE && !interrupt_controller_unit_irq;
  endsequence

  a_idle_entry: assert property (s_idle_write |=> mode == PSM_IDLE)
    else $error("idle write did not enter idle");

  a_timer_wake: assert property (s_timer_wake |=>
    mode == PSM_NORMAL && core_fetch_en && core_clk_en && ec_clk_en)
    else $error("core timer did not wake idle");

  a_doze_timer_ignored: assert property (s_doze_no_irq |=> mode == PSM_DOZE)
    else $error("doze left without an interrupt");

  a_sleep_hold: assert property (clk_en && mode == PSM_SLEEP && !interrupt_controller_unit_irq |=> mode == PSM_SLEEP)
    else $error("sleep left without an interrupt");

  a_normal_clocks: assert property (mode == PSM_NORMAL |->
    core_fetch_en && core_clk_en && ec_clk_en && wake_set_clk_en && !pll_off)
    else $error("normal mode with a clock stopped");

  a_code_follows: assert property (
    (mode == PSM_IDLE) == (mode_code == `PSM_CODE_IDLE) && (mode == PSM_DOZE) == (mode_code == `PSM_CODE_DOZE) &&
    (mode == PSM_SLEEP) == (mode_code == `PSM_CODE_SLEEP))
    else $error("mode code does not match mode");

  a_ctl_pull_normal: assert property (mode == PSM_NORMAL |-> flash_ctl_pull == 3'h0)
    else $error("flash control pull-downs on in normal mode");

  a_scan_out_write: assert property (clk_en && reg_wr && reg_addr == `PSM_OFS_SCAN_OUT_PULL |=>
    scan_out_pull == $past(reg_wdata[15:0]))
    else $error("scan output pull write lost");

  a_cfg_write: assert property (clk_en && reg_wr && reg_addr == `PSM_OFS_CFG |=>
    pll_sleep_sel == $past(reg_wdata[`PSM_BIT_PLL_SLEEP]))
    else $error("pll select write lost");

  a_freeze_state: assert property (!clk_en && !sys_rst |=>
    $stable(mode) && $stable(core_clk_en) && $stable(ec_clk_en) && $stable(scan_in_pull) && $stable(gpio7_pull))
    else $error("state moved while clock enable low");

  a_scan_read: assert property (clk_en && reg_rd && reg_addr == `PSM_OFS_SCAN_OUT_PULL |=>
    reg_rdata[15:0] == $past(scan_out_pull) && reg_rdata[`PSM_DW-1:16] == '0)
    else $error("scan output pull read wrong");

  a_status_read: assert property (clk_en && reg_rd && reg_addr == `PSM_OFS_STATUS |=>
    reg_rdata[`PSM_ST_MODE_HI:`PSM_ST_MODE_LO] == $past(mode_code) &&
    reg_rdata[`PSM_ST_STRAP_DONE] == $past(strap_done) &&
    reg_rdata[`PSM_ST_STRAP_HI:`PSM_ST_STRAP_LO] == $past(strap_value))
    else $error("status read does not match state");

  a_rdata_quiet: assert property (clk_en && !reg_rd |=> reg_rdata == '0)
    else $error("read data shown without a read");

  a_host_standby_off: assert property (clk_en && !sys_rst && host_standby |=> !host_unit_en)
    else $error("host units powered in standby");
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// self-checking testbench for the power-state gating block
`timescale 1ns/1ps
`default_nettype none
`include "psm_defs.svh"
module tb_top
  import psm_pkg::*;
;
  // ==========================================================
  // signals and design instance
  localparam int STRAP_CYC = 2;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic clk_en = 1'b1;
  logic [`PSM_AW-1:0] reg_addr = '0;
  logic [`PSM_DW-1:0] reg_wdata = '0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [`PSM_DW-1:0] reg_rdata;
  logic interrupt_controller_unit_irq = 1'b0;
  logic core_timer_irq = 1'b0;
  logic host_standby = 1'b0;
  logic [3:0] strap_pins = 4'hA;
  logic core_fetch_en, core_clk_en, ec_clk_en, wake_set_clk_en, pll_off, host_unit_en;
  logic [1:0] mode_code;
  logic [7:0] scan_in_pull, gpio7_pull, flash_data_pull;
  logic [15:0] scan_out_pull;
  logic [21:0] flash_addr_pull;
  logic [2:0] flash_ctl_pull;
  int fail_count = 0;
  int total_checks = 0;

  always #5 mclk = ~mclk;

  psm_top #(.GPIO7_PULL_RST(8'h00), .STRAP_CYC(STRAP_CYC)) u_dut (
    .mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .interrupt_controller_unit_irq(interrupt_controller_unit_irq),
    .core_timer_irq(core_timer_irq), .host_standby(host_standby), .strap_pins(strap_pins),
    .core_fetch_en(core_fetch_en), .core_clk_en(core_clk_en), .ec_clk_en(ec_clk_en),
    .wake_set_clk_en(wake_set_clk_en), .pll_off(pll_off), .host_unit_en(host_unit_en),
    .mode_code(mode_code), .scan_in_pull(scan_in_pull), .scan_out_pull(scan_out_pull),
    .gpio7_pull(gpio7_pull), .flash_addr_pull(flash_addr_pull), .flash_data_pull(flash_data_pull),
    .flash_ctl_pull(flash_ctl_pull)
  );

  // ==========================================================
  // access and compare tasks
  task automatic chk(input string nm, input logic [32:0] exp, input logic [32:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      fail_count++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk("read data", 33'(exp), 33'(reg_rdata));
  endtask

  // fetch, core clock, ec clock, wake set clock, pll off, mode
  task automatic chk_mode(input logic [6:0] exp);
    chk("mode outputs", 33'(exp), 33'({core_fetch_en, core_clk_en, ec_clk_en, wake_set_clk_en, pll_off, mode_code}));
  endtask

  task automatic chk_flash(input logic [32:0] exp);
    chk("flash pulls", exp, {flash_addr_pull, flash_data_pull, flash_ctl_pull});
  endtask

  task automatic irq(input logic use_interrupt_controller_unit);
    @(posedge mclk);
    if (use_interrupt_controller_unit) begin
      interrupt_controller_unit_irq <= 1'b1;
    end else begin
      core_timer_irq <= 1'b1;
    end
    @(posedge mclk);
    interrupt_controller_unit_irq <= 1'b0;
    core_timer_irq <= 1'b0;
    #1;
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // ==========================================================
  // test sequence
  initial begin
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk_mode(7'h78);
    chk_flash(33'h00001E000);
    chk("host after reset", 33'h0, 33'(host_unit_en));
    chk("scan pulls reset", 33'h0, 33'({scan_in_pull, scan_out_pull}));
    chk("gpio7 reset", 33'h0, 33'(gpio7_pull));
    repeat (STRAP_CYC + 3) @(posedge mclk);
    #1;
    chk_flash(33'h0);
    rd(`PSM_OFS_STATUS, 32'h000000AC);
    // strap level is captured once, later pin changes are ignored
    @(posedge mclk) strap_pins <= 4'h5;
    @(posedge mclk) host_standby <= 1'b1;
    @(posedge mclk);
    #1;
    chk("host standby", 33'h0, 33'(host_unit_en));
    @(posedge mclk) host_standby <= 1'b0;
    @(posedge mclk);
    #1;
    chk("host active", 33'h1, 33'(host_unit_en));
    wr(`PSM_OFS_SCAN_IN_PULL, 32'h0000005A);
    chk("scan in pull", 33'h5A, 33'(scan_in_pull));
    wr(`PSM_OFS_SCAN_OUT_PULL, 32'h0000A55A);
    wr(`PSM_OFS_GPIO7_PULL, 32'h00000081);
    chk("gpio7 pull", 33'h81, 33'(gpio7_pull));
    rd(`PSM_OFS_SCAN_OUT_PULL, 32'h0000A55A);
    rd(8'h20, 32'h0);
    wr(`PSM_OFS_STATUS, 32'hFFFFFFFF);
    rd(`PSM_OFS_STATUS, 32'h000000AC);
    // frozen while clk_en low, value kept afterwards
    @(posedge mclk) clk_en <= 1'b0;
    wr(`PSM_OFS_SCAN_IN_PULL, 32'h00000033);
    @(posedge mclk) clk_en <= 1'b1;
    @(posedge mclk);
    #1;
    chk("frozen scan pull", 33'h5A, 33'(scan_in_pull));
    // idle, then timer wake
    wr(`PSM_OFS_CORE_PWR, 32'h00000001);
    chk_mode(7'h39);
    chk_flash(33'h1FFFFFFFF);
    irq(1'b0);
    chk_mode(7'h78);
    chk_flash(33'h0);
    // doze: timer does not wake, interrupt_controller_unit does
    wr(`PSM_OFS_CFG, 32'h0);
    wr(`PSM_OFS_CORE_PWR, 32'h00000003);
    chk_mode(7'h1A);
    rd(`PSM_OFS_STATUS, 32'h000000AE);
    irq(1'b0);
    chk_mode(7'h1A);
    irq(1'b1);
    chk_mode(7'h78);
    // sleep: idle write ignored, interrupt_controller_unit wakes
    wr(`PSM_OFS_CFG, 32'h1);
    wr(`PSM_OFS_CORE_PWR, 32'h00000002);
    chk_mode(7'h0F);
    chk_flash(33'h1FFFFFFFF);
    wr(`PSM_OFS_CORE_PWR, 32'h00000001);
    chk_mode(7'h0F);
    irq(1'b1);
    chk_mode(7'h78);
    chk("scan pull kept", 33'h5A, 33'(scan_in_pull));
    // mid-run reset: pulls back to defaults, strap taken again
    @(posedge mclk) sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    chk("scan pulls reset again", 33'h0, 33'({scan_in_pull, scan_out_pull}));
    chk_flash(33'h00001E000);
    repeat (STRAP_CYC + 3) @(posedge mclk);
    rd(`PSM_OFS_STATUS, 32'h0000005C);
    stop_test();
  end

  // ==========================================================
  // watchdog
  initial begin
    #20000;
    fail_count++;
    stop_test();
  end
endmodule
`default_nettype wire
